// file: verilog/sfb_bank.sv
// bank 0 special function register file with shared core registers and a bank 1 serial status shadow
//
// Behaviour
// - registers are storage beside general ram
// - core registers decoded same in both banks
// - upper pc bits reachable only via holding
// - five holding bits load pc bits 12:8
// - clear and watchdog resets use other values
// - unchanged bits kept, condition bits from cause
// - indirect bank and high bank bits reserved
// - unimplemented locations and bits read zero
// - port writes latch, reads return pins
// - serial status top two bits read zero
// - status bit 5 selects direct bank, bits 6:5 drive bank_out
`timescale 1ns/1ns
module sfb_bank
   import sfb_pkg::*;
#(
   parameter int GPR_WORDS = SFB_GPR_WORDS
) (
   input  wire logic       clk_in,
   input  wire logic       srst_in,
   input  wire logic       por_in,
   input  wire logic       wdt_in,
   input  wire logic       sleep_in,
   input  wire logic [7:0] addr_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       wr_in,
   input  wire logic       rd_in,
   output logic      [7:0] rdata_out,
   input  wire logic       pc_load_in,
   input  wire logic [7:0] pc_low_in,
   input  wire logic       pc_upper_load_in,
   output logic      [12:0] pc_out,
   input  wire logic [5:0] port_a_pins_in,
   input  wire logic [7:0] port_b_pins_in,
   input  wire logic [7:0] port_c_pins_in,
   output logic      [5:0] port_a_latch_out,
   output logic      [7:0] port_b_latch_out,
   output logic      [7:0] port_c_latch_out,
   input  wire logic [7:0] converter_result_in,
   output logic      [7:0] t1ctl_out,
   output logic      [7:0] t2ctl_out,
   output logic      [7:0] serctl_out,
   output logic      [7:0] ccctl_out,
   output logic      [7:0] adctl0_out,
   output logic      [7:0] intctl_out,
   output logic      [1:0] bank_out
);
   ////////////////////////////////////////////////////////////////////////////
   sfb_req_t      req;
   sfb_rst_kind_t rst_kind;
   logic [6:0]    dir_idx;
   logic [6:0]    eff_idx;
   logic          eff_bank;
   logic          shared_hit;
   logic [7:0]    rd_d;
   logic [7:0]    gpr_rdata;
   logic          gpr_we;
   logic [6:0]    gpr_idx;

   logic [7:0] status_q;
   logic [7:0] pointer_q;
   logic [4:0] pchold_q;
   logic [12:0] pc_q;
   logic [7:0] intctl_q, pflags1_q, timer_zero_count_q, t1l_q, t1h_q, t1ctl_q, t2cnt_q, t2ctl_q;
   logic [7:0] serbuf_q, serctl_q, ccl_q, cch_q, ccctl_q, adctl0_q, serstat_q;
   logic [5:0] port_a_data_q;
   logic [7:0] port_b_data_q, port_c_data_q;
   logic [7:0] rdata_q;

   assign req.addr  = addr_in[6:0];
   assign req.wdata = wdata_in;
   assign req.wr    = wr_in;
   assign req.rd    = rd_in;

   // power-on reset when srst and por both asserted, otherwise clear/watchdog reset kind when srst or wdt is asserted
   always_comb begin
      if (srst_in && por_in) rst_kind = SFB_RST_POWER;
      else if (srst_in || wdt_in) rst_kind = SFB_RST_OTHER;
      else rst_kind = SFB_RST_NONE;
   end

   ////////////////////////////////////////////////////////////////////////////
   // address decode: indirect window redirects through the pointer
   always_comb begin
      if (req.addr == SFB_ADDR_INDIRECT) begin
         eff_idx  = pointer_q[6:0];
         eff_bank = pointer_q[7];
      end else begin
         eff_idx  = req.addr;
         eff_bank = status_q[SFB_ST_BANKLO];
      end
   end
   assign dir_idx = eff_idx;

   // core registers ignore the bank bit
   assign shared_hit = (dir_idx == SFB_ADDR_PCL) || (dir_idx == SFB_ADDR_STATUS) ||
                       (dir_idx == SFB_ADDR_POINTER) || (dir_idx == SFB_ADDR_PCHOLD) ||
                       (dir_idx == SFB_ADDR_INTCTL) || (dir_idx == SFB_ADDR_INDIRECT);

   // general ram only in bank 0; bank 1 upper area is unimplemented here
   assign gpr_idx = dir_idx - SFB_GPR_FIRST;
   assign gpr_we  = req.wr && !eff_bank && (dir_idx >= SFB_GPR_FIRST);

   sfb_gpr #(
      .WORDS (GPR_WORDS)
   ) u_gpr (
      .clk_in    (clk_in),
      .idx_in    (gpr_idx),
      .wdata_in  (req.wdata),
      .we_in     (gpr_we),
      .rdata_out (gpr_rdata)
   );

   ////////////////////////////////////////////////////////////////////////////
   // status register
   always_ff @(posedge clk_in) begin
      if (rst_kind == SFB_RST_POWER) begin
         status_q <= SFB_RST_STATUS_POR;
      end else if (rst_kind == SFB_RST_OTHER) begin
         // bank bits cleared, flags kept, timeout/powerdown from cause
         status_q[7:5]            <= 3'h0;
         status_q[SFB_ST_TIMEOUT] <= !wdt_in;
         status_q[SFB_ST_PWRDN]   <= !(wdt_in && sleep_in) || !wdt_in;
      end else if (req.wr && shared_hit && dir_idx == SFB_ADDR_STATUS) begin
         // reserved bank bits are kept clear whatever is written
         status_q <= (req.wdata & SFB_MASK_STATUS_WR & 8'h3f) |
                     (status_q & ~SFB_MASK_STATUS_WR);
      end
   end

   // pointer, holding register and program counter
   always_ff @(posedge clk_in) begin
      if (rst_kind == SFB_RST_NONE && req.wr && dir_idx == SFB_ADDR_POINTER) begin
         pointer_q <= req.wdata;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_kind != SFB_RST_NONE) begin
         pchold_q <= SFB_RST_PCHOLD;
      end else if (req.wr && dir_idx == SFB_ADDR_PCHOLD) begin
         pchold_q <= req.wdata[4:0];
      end
   end

   // upper pc only changes from the holding register, or clears to zero on any reset
   always_ff @(posedge clk_in) begin
      if (rst_kind != SFB_RST_NONE) begin
         pc_q <= 13'h0000;
      end else if (req.wr && dir_idx == SFB_ADDR_PCL) begin
         pc_q <= {pchold_q, req.wdata};
      end else if (pc_upper_load_in) begin
         pc_q <= {pchold_q, pc_low_in};
      end else if (pc_load_in) begin
         pc_q <= {pc_q[12:8], pc_low_in};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bank 0 peripheral registers and the bank 1 serial status shadow
   always_ff @(posedge clk_in) begin
      if (rst_kind == SFB_RST_POWER) begin
         intctl_q <= SFB_RST_ZERO;
         t1ctl_q  <= SFB_RST_ZERO;
      end else if (rst_kind == SFB_RST_OTHER) begin
         intctl_q[7:1] <= 7'h00;
      end else if (req.wr && dir_idx == SFB_ADDR_INTCTL) begin
         intctl_q <= req.wdata;
      end else if (req.wr && !eff_bank && dir_idx == SFB_ADDR_T1CTL) begin
         t1ctl_q <= req.wdata & SFB_MASK_T1CTL;
      end
   end

   always_ff @(posedge clk_in) begin
      if (rst_kind != SFB_RST_NONE) begin
         pflags1_q <= SFB_RST_ZERO;
         t2cnt_q   <= SFB_RST_ZERO;
         t2ctl_q   <= SFB_RST_ZERO;
         serctl_q  <= SFB_RST_ZERO;
         ccctl_q   <= SFB_RST_ZERO;
         adctl0_q  <= SFB_RST_ZERO;
         serstat_q <= SFB_RST_ZERO;
      end else if (req.wr && !eff_bank) begin
         case (dir_idx)
            SFB_ADDR_PFLAGS1: pflags1_q <= req.wdata & SFB_MASK_PFLAGS1;
            SFB_ADDR_T2CNT:   t2cnt_q   <= req.wdata;
            SFB_ADDR_T2CTL:   t2ctl_q   <= req.wdata & SFB_MASK_T2CTL;
            SFB_ADDR_SERCTL:  serctl_q  <= req.wdata;
            SFB_ADDR_CCCTL:   ccctl_q   <= req.wdata & SFB_MASK_CCCTL;
            SFB_ADDR_ADCTL0:  adctl0_q  <= req.wdata & SFB_MASK_ADCTL0;
            default: ;
         endcase
      end else if (req.wr && eff_bank && dir_idx == SFB_ADDR_SERSTAT) begin
         serstat_q <= req.wdata & SFB_MASK_SERSTAT;
      end
   end

   // registers with unknown power-up value and unchanged on other resets
   always_ff @(posedge clk_in) begin
      if (rst_kind == SFB_RST_NONE && req.wr && !eff_bank) begin
         case (dir_idx)
            SFB_ADDR_TIMER_ZERO_COUNT:   timer_zero_count_q   <= req.wdata;
            SFB_ADDR_PORT_A_DATA:  port_a_data_q  <= req.wdata[5:0];
            SFB_ADDR_PORT_B_DATA:  port_b_data_q  <= req.wdata;
            SFB_ADDR_PORT_C_DATA:  port_c_data_q  <= req.wdata;
            SFB_ADDR_T1L:    t1l_q    <= req.wdata;
            SFB_ADDR_T1H:    t1h_q    <= req.wdata;
            SFB_ADDR_SERBUF: serbuf_q <= req.wdata;
            SFB_ADDR_CCL:    ccl_q    <= req.wdata;
            SFB_ADDR_CCH:    cch_q    <= req.wdata;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // read mux
   always_comb begin
      rd_d = 8'h00;
      if (shared_hit) begin
         case (dir_idx)
            SFB_ADDR_PCL:     rd_d = pc_q[7:0];
            SFB_ADDR_STATUS:  rd_d = status_q;
            SFB_ADDR_POINTER: rd_d = pointer_q;
            SFB_ADDR_PCHOLD:  rd_d = {3'h0, pchold_q};
            SFB_ADDR_INTCTL:  rd_d = intctl_q;
            default:          rd_d = 8'h00;  // indirect through itself reads zero
         endcase
      end else if (dir_idx >= SFB_GPR_FIRST) begin
         rd_d = eff_bank ? 8'h00 : gpr_rdata;
      end else if (eff_bank) begin
         rd_d = (dir_idx == SFB_ADDR_SERSTAT) ? (serstat_q & SFB_MASK_SERSTAT) : 8'h00;
      end else begin
         case (dir_idx)
            SFB_ADDR_TIMER_ZERO_COUNT:    rd_d = timer_zero_count_q;
            SFB_ADDR_PORT_A_DATA:   rd_d = {2'h0, port_a_pins_in};
            SFB_ADDR_PORT_B_DATA:   rd_d = port_b_pins_in;
            SFB_ADDR_PORT_C_DATA:   rd_d = port_c_pins_in;
            SFB_ADDR_PFLAGS1: rd_d = pflags1_q;
            SFB_ADDR_T1L:     rd_d = t1l_q;
            SFB_ADDR_T1H:     rd_d = t1h_q;
            SFB_ADDR_T1CTL:   rd_d = t1ctl_q;
            SFB_ADDR_T2CNT:   rd_d = t2cnt_q;
            SFB_ADDR_T2CTL:   rd_d = t2ctl_q;
            SFB_ADDR_SERBUF:  rd_d = serbuf_q;
            SFB_ADDR_SERCTL:  rd_d = serctl_q;
            SFB_ADDR_CCL:     rd_d = ccl_q;
            SFB_ADDR_CCH:     rd_d = cch_q;
            SFB_ADDR_CCCTL:   rd_d = ccctl_q;
            SFB_ADDR_CONVERTER_RESULT:   rd_d = converter_result_in;
            SFB_ADDR_ADCTL0:  rd_d = adctl0_q;
            default:          rd_d = 8'h00;
         endcase
      end
   end

   always_ff @(posedge clk_in) begin
      if (srst_in) begin
         rdata_q <= 8'h00;
      end else if (req.rd) begin
         rdata_q <= rd_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   assign rdata_out        = rdata_q;
   assign pc_out           = pc_q;
   assign port_a_latch_out = port_a_data_q;
   assign port_b_latch_out = port_b_data_q;
   assign port_c_latch_out = port_c_data_q;
   assign t1ctl_out        = t1ctl_q;
   assign t2ctl_out        = t2ctl_q;
   assign serctl_out       = serctl_q;
   assign ccctl_out        = ccctl_q;
   assign adctl0_out       = adctl0_q;
   assign intctl_out       = intctl_q;
   assign bank_out         = status_q[6:5];
endmodule

// file: verilog/sfb_pkg.sv
// package: register map, field positions and reset values of the bank 0 register file
package sfb_pkg;
   localparam logic [6:0] SFB_ADDR_INDIRECT   = 7'h00;
   localparam logic [6:0] SFB_ADDR_TIMER_ZERO_COUNT       = 7'h01;
   localparam logic [6:0] SFB_ADDR_PCL        = 7'h02;
   localparam logic [6:0] SFB_ADDR_STATUS     = 7'h03;
   localparam logic [6:0] SFB_ADDR_POINTER    = 7'h04;
   localparam logic [6:0] SFB_ADDR_PORT_A_DATA      = 7'h05;
   localparam logic [6:0] SFB_ADDR_PORT_B_DATA      = 7'h06;
   localparam logic [6:0] SFB_ADDR_PORT_C_DATA      = 7'h07;
   localparam logic [6:0] SFB_ADDR_PCHOLD     = 7'h0a;
   localparam logic [6:0] SFB_ADDR_INTCTL     = 7'h0b;
   localparam logic [6:0] SFB_ADDR_PFLAGS1    = 7'h0c;
   localparam logic [6:0] SFB_ADDR_T1L        = 7'h0e;
   localparam logic [6:0] SFB_ADDR_T1H        = 7'h0f;
   localparam logic [6:0] SFB_ADDR_T1CTL      = 7'h10;
   localparam logic [6:0] SFB_ADDR_T2CNT      = 7'h11;
   localparam logic [6:0] SFB_ADDR_T2CTL      = 7'h12;
   localparam logic [6:0] SFB_ADDR_SERBUF     = 7'h13;
   localparam logic [6:0] SFB_ADDR_SERCTL     = 7'h14;
   localparam logic [6:0] SFB_ADDR_CCL        = 7'h15;
   localparam logic [6:0] SFB_ADDR_CCH        = 7'h16;
   localparam logic [6:0] SFB_ADDR_CCCTL      = 7'h17;
   localparam logic [6:0] SFB_ADDR_CONVERTER_RESULT      = 7'h1e;
   localparam logic [6:0] SFB_ADDR_ADCTL0     = 7'h1f;
   localparam logic [6:0] SFB_ADDR_SERSTAT    = 7'h14; // bank 1 only
   localparam logic [6:0] SFB_GPR_FIRST       = 7'h20;

   // implemented-bit masks
   localparam logic [7:0] SFB_MASK_PORT_A_DATA      = 8'h3f;
   localparam logic [7:0] SFB_MASK_PCHOLD     = 8'h1f;
   localparam logic [7:0] SFB_MASK_PFLAGS1    = 8'h4f;
   localparam logic [7:0] SFB_MASK_T1CTL      = 8'h3f;
   localparam logic [7:0] SFB_MASK_T2CTL      = 8'h7f;
   localparam logic [7:0] SFB_MASK_CCCTL      = 8'h3f;
   localparam logic [7:0] SFB_MASK_ADCTL0     = 8'hfd;
   localparam logic [7:0] SFB_MASK_SERSTAT    = 8'h3f;
   localparam logic [7:0] SFB_MASK_STATUS_WR  = 8'h67; // timeout/powerdown bits are hardware only

   // status field positions
   localparam int SFB_ST_INDBANK  = 7;
   localparam int SFB_ST_BANKHI   = 6;
   localparam int SFB_ST_BANKLO   = 5;
   localparam int SFB_ST_TIMEOUT  = 4;
   localparam int SFB_ST_PWRDN    = 3;

   // reset values
   localparam logic [7:0] SFB_RST_ZERO        = 8'h00;
   localparam logic [7:0] SFB_RST_STATUS_POR  = 8'h18;
   localparam logic [4:0] SFB_RST_PCHOLD      = 5'h00;

   localparam int SFB_GPR_WORDS = 96;

   typedef enum logic [1:0] {SFB_RST_NONE, SFB_RST_POWER, SFB_RST_OTHER} sfb_rst_kind_t;

   typedef struct packed {
      logic [6:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } sfb_req_t;
endpackage

// file: verilog/sfb_gpr.sv
// general purpose ram of the bank, flip-flop storage
`timescale 1ns/1ns
module sfb_gpr
   import sfb_pkg::*;
#(
   parameter int WORDS = SFB_GPR_WORDS
) (
   input  wire logic       clk_in,
   input  wire logic [6:0] idx_in,
   input  wire logic [7:0] wdata_in,
   input  wire logic       we_in,
   output logic      [7:0] rdata_out
);
   logic [7:0] mem_q [WORDS];

   // storage has no reset: contents are unknown at power up
   always_ff @(posedge clk_in) begin
      if (we_in && int'(idx_in) < WORDS) begin
         mem_q[idx_in] <= wdata_in;
      end
   end

   assign rdata_out = (int'(idx_in) < WORDS) ? mem_q[idx_in] : 8'h00;
endmodule

// file: verification/sfb_bank_checker.sv
// checker: port-level assertions for the bank 0 register file
`timescale 1ns/1ns
module sfb_bank_checker
   import sfb_pkg::*;
(
   input wire logic        clk_in,
   input wire logic        srst_in,
   input wire logic        por_in,
   input wire logic        wdt_in,
   input wire logic [7:0]  addr_in,
   input wire logic [7:0]  wdata_in,
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire logic [7:0]  rdata_out,
   input wire logic        pc_load_in,
   input wire logic [7:0]  pc_low_in,
   input wire logic        pc_upper_load_in,
   input wire logic [12:0] pc_out,
   input wire logic [7:0]  port_b_pins_in,
   input wire logic [7:0]  port_c_latch_out,
   input wire logic [7:0]  intctl_out,
   input wire logic [7:0]  t1ctl_out,
   input wire logic [7:0]  t2ctl_out,
   input wire logic [1:0]  bank_out
);
   default clocking cb @(posedge clk_in); endclocking
   default disable iff (srst_in);
   logic [6:0] a;
   assign a = addr_in[6:0];
   ////////////////////////////////////////////////////////////////////////////
   sequence hold_then_load;
      wr_in && a == SFB_ADDR_PCHOLD ##1 pc_upper_load_in && !wr_in;
   endsequence
   // reset checks must run while reset is high, so they drop the default disable
   pwr_reset_a: assert property (disable iff (1'b0) srst_in && por_in |=> pc_out == 13'h0000 && intctl_out == 8'h00)
      else $error("power reset values wrong");
   other_reset_a: assert property (disable iff (1'b0) srst_in && !por_in |=> t2ctl_out == 8'h00 && t1ctl_out == $past(t1ctl_out))
      else $error("other reset values wrong");
   wdt_keep_a: assert property (wdt_in |=> intctl_out == {7'h00, $past(intctl_out[0])} && bank_out == 2'h0)
      else $error("watchdog reset values wrong");
   unimpl_read_a: assert property (rd_in && a inside {7'h08, 7'h09, 7'h0d, [7'h18:7'h1d]} |=> rdata_out == 8'h00)
      else $error("unimplemented location not zero");
   hold_bits_a: assert property (rd_in && a == SFB_ADDR_PCHOLD |=> rdata_out[7:5] == 3'h0)
      else $error("holding upper bits not zero");
   port_read_a: assert property (rd_in && a == SFB_ADDR_PORT_B_DATA && bank_out == 2'h0 |=> rdata_out == $past(port_b_pins_in))
      else $error("port read not pins");
   port_latch_a: assert property (wr_in && a == SFB_ADDR_PORT_C_DATA && bank_out == 2'h0 |=> port_c_latch_out == $past(wdata_in))
      else $error("port latch not written");
   pc_upper_a: assert property (hold_then_load |=> pc_out[12:8] == $past(wdata_in[4:0], 2))
      else $error("upper pc not from holding");
   pc_low_a: assert property (pc_load_in && !wr_in |=> pc_out[7:0] == $past(pc_low_in))
      else $error("pc low not loaded");
   serstat_a: assert property (rd_in && a == SFB_ADDR_SERSTAT && bank_out == 2'h1 |=> rdata_out[7:6] == 2'h0)
      else $error("serial status top bits not zero");
   bank_sel_a: assert property (wr_in && a == SFB_ADDR_STATUS |=> bank_out == {1'b0, $past(wdata_in[5])})
      else $error("bank select not from status");
   shared_ctl_a: assert property (rd_in && a == SFB_ADDR_INTCTL |=> rdata_out == $past(intctl_out))
      else $error("shared register read wrong");
   read_hold_a: assert property (!rd_in |=> $stable(rdata_out))
      else $error("read data moved without read");
   cover property (rd_in && bank_out == 2'h1);
   cover property (wdt_in);
   cover property (hold_then_load);
endmodule

// file: verification/tb.sv
// testbench: register reads and writes against the bank 0 map
`timescale 1ns/1ns
module tb;
   import sfb_pkg::*;
   logic clk_in = 1'b0, srst_in = 1'b1, por_in = 1'b1, wdt_in = 1'b0, sleep_in = 1'b0;
   logic [7:0] addr_in = 8'h00, wdata_in = 8'h00, pc_low_in = 8'h00, converter_result_in = 8'hc3;
   logic wr_in = 1'b0, rd_in = 1'b0, pc_load_in = 1'b0, pc_upper_load_in = 1'b0;
   logic [5:0] port_a_pins_in = 6'h2a;
   logic [7:0] port_b_pins_in = 8'h5c, port_c_pins_in = 8'ha3;
   logic [7:0] rdata_out, t1ctl_out, t2ctl_out, serctl_out, ccctl_out, adctl0_out, intctl_out;
   logic [7:0] port_b_latch_out, port_c_latch_out;
   logic [5:0] port_a_latch_out;
   logic [12:0] pc_out;
   logic [1:0] bank_out;
   int fail_count = 0, n_compared = 0;
   // write-all-ones table: address and the bits that must read back
   logic [7:0] ta [13] = '{8'h0a, 8'h0c, 8'h10, 8'h12, 8'h17, 8'h1f, 8'h14, 8'h01, 8'h08, 8'h09, 8'h0d, 8'h18, 8'h1d};
   logic [7:0] tm [13] = '{8'h1f, 8'h4f, 8'h3f, 8'h7f, 8'h3f, 8'hfd, 8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

   sfb_bank i_sfb_bank (.clk_in(clk_in), .srst_in(srst_in), .por_in(por_in), .wdt_in(wdt_in), .sleep_in(sleep_in),
      .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
      .pc_load_in(pc_load_in), .pc_low_in(pc_low_in), .pc_upper_load_in(pc_upper_load_in), .pc_out(pc_out),
      .port_a_pins_in(port_a_pins_in), .port_b_pins_in(port_b_pins_in), .port_c_pins_in(port_c_pins_in),
      .port_a_latch_out(port_a_latch_out), .port_b_latch_out(port_b_latch_out), .port_c_latch_out(port_c_latch_out),
      .converter_result_in(converter_result_in), .t1ctl_out(t1ctl_out), .t2ctl_out(t2ctl_out), .serctl_out(serctl_out),
      .ccctl_out(ccctl_out), .adctl0_out(adctl0_out), .intctl_out(intctl_out), .bank_out(bank_out));

   initial begin
      forever #10 clk_in = ~clk_in;
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [15:0] got, input logic [15:0] exp);
      n_compared++;
      if (got !== exp) begin
         fail_count++;
         $display("[ERR] %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge clk_in);
      addr_in <= a;
      wdata_in <= d;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
      #1;
   endtask
   // read data are captured at the edge that samples the strobe and held until the next read, so sample right after that edge
   task automatic rd(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
      @(posedge clk_in);
      addr_in <= a;
      rd_in <= 1'b1;
      @(posedge clk_in);
      rd_in <= 1'b0;
      #1;
      chk({8'h00, rdata_out & m}, {8'h00, e});
   endtask
   task automatic pulse(input logic w, input logic p, input logic s);
      @(posedge clk_in);
      wdt_in <= w;
      pc_load_in <= p;
      pc_upper_load_in <= p;
      srst_in <= s;
      por_in <= 1'b0;
      pc_low_in <= 8'h77;
      @(posedge clk_in);
      {wdt_in, pc_load_in, pc_upper_load_in, srst_in} <= 4'h0;
      #1;
   endtask
   task automatic end_of_test;
      $display("compared %0d, mismatches %0d", n_compared, fail_count);
      if (fail_count == 0 && n_compared > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (3000) @(posedge clk_in);
      fail_count++;
      end_of_test();
   end
   initial begin
      repeat (2) @(posedge clk_in);
      srst_in <= 1'b0;
      por_in <= 1'b0;
      rd(SFB_ADDR_STATUS, 8'hf8, 8'h18);
      rd(SFB_ADDR_PCHOLD, 8'hff, 8'h00);
      chk({3'h0, pc_out}, 16'h0000);
      for (int i = 0; i < 13; i++) begin
         wr(ta[i], 8'hff);
         rd(ta[i], 8'hff, tm[i]);
      end
      pulse(1'b0, 1'b1, 1'b0);
      chk({3'h0, pc_out}, 16'h1f77);
      wr(SFB_ADDR_PCL, 8'h34);
      chk({3'h0, pc_out}, 16'h1f34);
      wr(SFB_ADDR_PORT_B_DATA, 8'h81);
      chk({8'h00, port_b_latch_out}, 16'h0081);
      rd(SFB_ADDR_PORT_B_DATA, 8'hff, 8'h5c);
      wr(SFB_ADDR_PORT_A_DATA, 8'hff);
      rd(SFB_ADDR_PORT_A_DATA, 8'hff, 8'h2a);
      chk({10'h000, port_a_latch_out}, 16'h003f);
      wr(SFB_ADDR_PORT_C_DATA, 8'h3c);
      rd(SFB_ADDR_PORT_C_DATA, 8'hff, 8'ha3);
      wr(SFB_ADDR_CONVERTER_RESULT, 8'h00);
      rd(SFB_ADDR_CONVERTER_RESULT, 8'hff, 8'hc3);
      wr(SFB_ADDR_POINTER, 8'h21);
      wr(SFB_ADDR_INDIRECT, 8'h5a);
      rd(8'h21, 8'hff, 8'h5a);
      rd(SFB_ADDR_INDIRECT, 8'hff, 8'h5a);
      wr(SFB_ADDR_INTCTL, 8'hff);
      wr(SFB_ADDR_STATUS, 8'h20);
      chk({14'h0000, bank_out}, 16'h0001);
      rd(SFB_ADDR_INTCTL, 8'hff, 8'hff);
      rd(SFB_ADDR_SERSTAT, 8'hc0, 8'h00);
      wr(SFB_ADDR_PCHOLD, 8'h05);
      wr(SFB_ADDR_STATUS, 8'h00);
      rd(SFB_ADDR_PCHOLD, 8'hff, 8'h05);
      // holding write directly followed by an upper load, so the holding value feeds the counter at once
      @(posedge clk_in);
      addr_in <= {1'b0, SFB_ADDR_PCHOLD};
      wdata_in <= 8'h0c;
      wr_in <= 1'b1;
      @(posedge clk_in);
      wr_in <= 1'b0;
      pc_upper_load_in <= 1'b1;
      pc_low_in <= 8'h12;
      @(posedge clk_in);
      pc_upper_load_in <= 1'b0;
      #1;
      chk({3'h0, pc_out}, 16'h0c12);
      pulse(1'b1, 1'b0, 1'b0);
      chk({intctl_out, t1ctl_out}, 16'h013f);
      rd(SFB_ADDR_STATUS, 8'hf8, 8'h08);
      // watchdog while asleep clears the powerdown bit as well
      @(posedge clk_in);
      sleep_in <= 1'b1;
      pulse(1'b1, 1'b0, 1'b0);
      rd(SFB_ADDR_STATUS, 8'hf8, 8'h00);
      @(posedge clk_in);
      sleep_in <= 1'b0;
      pulse(1'b0, 1'b0, 1'b1);
      rd(SFB_ADDR_STATUS, 8'hf8, 8'h18);
      chk({port_b_latch_out, t2ctl_out}, 16'h8100);
      end_of_test();
   end
endmodule
bind sfb_bank sfb_bank_checker i_chk (.clk_in(clk_in), .srst_in(srst_in), .por_in(por_in), .wdt_in(wdt_in),
   .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
   .pc_load_in(pc_load_in), .pc_low_in(pc_low_in), .pc_upper_load_in(pc_upper_load_in), .pc_out(pc_out),
   .port_b_pins_in(port_b_pins_in), .port_c_latch_out(port_c_latch_out), .intctl_out(intctl_out),
   .t1ctl_out(t1ctl_out), .t2ctl_out(t2ctl_out), .bank_out(bank_out));
